// ---- hdl/wior_repeater.sv ----
// radio i/o repeater core: per-pin link configuration, input sampling, periodic packet
// issue with randomized spacing, and output update from received peer packets.
// assumes the modem delivers only packets that passed its own checks, as a one-cycle strobe,
// and takes an outgoing packet on the cycle tx_valid is high.
//
// Behaviour
// R1 - A pin with pairing code zero stays an input and its level is used nowhere.
// R2 - A pin with code -1 to -127 is an input whose level goes into outgoing packets.
// R3 - A pin with code 1 to 127 is an output driven by the peer input with the negated code.
// R4 - Local inputs never drive local outputs; only received levels update outputs.
// R5 - With at least one input configured exactly one packet leaves every 7 to 10 ms.
// R6 - Each packet carries the pairing code and sampled level of every local input.
// R7 - A received packet updates every output whose code negates a reported input code.
// R8 - The pin set is port 0 pins 0-5, port 1 pins 0-7 and port 2 pin 1, the red indicator.
// R9 - Inputs get a pull-up except port 1 pins 0 and 1, which float.
// R10 - Every output drives low after reset until a packet changes it.
// R11 - The channel is an eight-bit value with reset default 128, shared by all peers.
// R12 - One pairing code is held for each pin, indexed by port and pin number.
// R13 - By default port 0 pin 0 has code -1, the red indicator code 1, others disabled.
// R14 - Packet timing is randomized so two peers started together drift apart.
// R15 - Each level is a single binary value.
// R16 - Peers must not give one negative code to inputs on two devices.
// R17 - An output keeps its last received level with no timeout.
`timescale 1ns/1ps

module wior_repeater (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	// pins, index 0-5 port 0, 6-13 port 1, 14 port 2 pin 1
	input  wire logic [14:0]          pin_in,
	output logic      [14:0]          pin_out,
	output logic      [14:0]          pin_oe,
	output logic      [14:0]          pin_pullup,
	// radio channel to the modem
	output logic      [7:0]           radio_channel,
	// outgoing packet
	output wior_pkg::wior_packet_s    tx_packet,
	output logic                      tx_valid,
	// received packet
	input  wire wior_pkg::wior_packet_s rx_packet,
	input  wire logic                 rx_valid
);

	//////////////////////////////////////////////////////////////////////////////////////
	// helpers

	// code is a signed byte: input when negative and not -128
	function automatic logic is_input(input logic [7:0] code);
		is_input = code[7] && (code != wior_pkg::LINK_FORBIDDEN);
	endfunction : is_input

	// positive nonzero code marks an output
	function automatic logic is_output(input logic [7:0] code);
		is_output = !code[7] && (code != wior_pkg::LINK_DISABLED);
	endfunction : is_output

	// pairing code register byte address to flat slot, 4'hF when no such pin
	// word 0-5 port 0, word 8-15 port 1, word 17 port 2 pin 1
	// every other word is a hole and maps to no slot
	function automatic logic [3:0] link_slot(input logic [7:0] addr);
		logic [7:0] word;
		word = (addr - wior_pkg::REG_LINK_BASE) >> 2;
		link_slot = 4'hF;
		if (word < 8'h06)
			link_slot = word[3:0];
		else if (word >= 8'h08 && word < 8'h10)
			link_slot = 4'(word - 8'h02);
		else if (word == 8'h11)
			link_slot = 4'hE;
	endfunction : link_slot

	//////////////////////////////////////////////////////////////////////////////////////
	// configuration state

	logic [7:0]  link_code [wior_pkg::NPINS];
	logic [15:0] lfsr;
	logic [14:0] pin_in_q;
	logic [14:0] in_mask;
	logic [14:0] out_mask;
	logic        any_input;
	logic        addr_is_link;
	logic [3:0]  wr_slot;

	assign addr_is_link = (reg_addr >= wior_pkg::REG_LINK_BASE)
	                   && (reg_addr <= wior_pkg::REG_LINK_LAST)
	                   && (reg_addr[1:0] == 2'b00);
	assign wr_slot      = addr_is_link ? link_slot(reg_addr) : 4'hF;

	// channel register, reset 128, eight bits only
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			radio_channel <= wior_pkg::CHANNEL_RESET;                // [R11]
		else if (reg_wr && reg_addr == wior_pkg::REG_CHANNEL)
			radio_channel <= reg_wdata[7:0];                         // [R11]
	end

	// one pairing code per pin, slots laid out by port and pin number
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < wior_pkg::NPINS; i++)
				link_code[i] <= wior_pkg::LINK_DISABLED;             // [R13]
			link_code[0]                       <= wior_pkg::LINK_P00_RESET; // [R13]
			link_code[wior_pkg::P2_LED_INDEX]  <= wior_pkg::LINK_LED_RESET; // [R13]
		end else if (reg_wr && wr_slot != 4'hF) begin
			link_code[wr_slot] <= reg_wdata[7:0];                    // [R12] [R8]
		end
	end

	// pin direction classes from the codes; -128 counts as disabled
	always_comb begin
		for (int i = 0; i < wior_pkg::NPINS; i++) begin
			in_mask[i]  = is_input(link_code[i]);                    // [R2]
			out_mask[i] = is_output(link_code[i]);                   // [R3] [R1]
		end
	end
	assign any_input = |in_mask;

	// drivers and pull-ups; disabled pins stay undriven inputs
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_oe     <= 15'h0000;
			pin_pullup <= 15'h0000;
		end else begin
			pin_oe <= out_mask;                                      // [R3] [R1]
			for (int i = 0; i < wior_pkg::NPINS; i++)
				pin_pullup[i] <= in_mask[i]
				              && (i != wior_pkg::P1_FLOAT_A) && (i != wior_pkg::P1_FLOAT_B); // [R9]
		end
	end

	// input sample register, one bit per pin
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			pin_in_q <= 15'h0000;
		else
			pin_in_q <= pin_in;                                      // [R15]
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// transmit interval timing

	logic [9:0] tick_cnt;
	logic       tick;
	logic [9:0] ivl_cnt;
	logic [9:0] ivl_target;
	logic       ivl_done;

	// 10 us tick enable keeps the interval counter small
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			tick_cnt <= 10'h000;
		else if (tick)
			tick_cnt <= 10'h000;
		else
			tick_cnt <= tick_cnt + 10'h001;
	end
	assign tick = (tick_cnt == 10'(wior_pkg::TICK_CYCLES - 1));

	// free-running lfsr; software may reseed it so two parts never share a sequence
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			lfsr <= wior_pkg::SEED_RESET;
		else if (reg_wr && reg_addr == wior_pkg::REG_SEED && reg_wdata[15:0] != 16'h0000)
			lfsr <= reg_wdata[15:0];
		else
			lfsr <= lfsr[0] ? ((lfsr >> 1) ^ wior_pkg::LFSR_TAPS) : (lfsr >> 1); // [R14]
	end

	assign ivl_done = tick && (ivl_cnt >= ivl_target);

	// interval counter; a fresh random span is drawn at each packet
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ivl_cnt    <= 10'h000;
			ivl_target <= 10'(wior_pkg::TX_MIN_TICKS);
		end else if (!any_input) begin
			ivl_cnt    <= 10'h000;                                   // [R5]
		end else if (ivl_done) begin
			ivl_cnt    <= 10'h001;
			// span 0..255 of 300 ticks stays inside the window
			ivl_target <= 10'(wior_pkg::TX_MIN_TICKS) + {2'b00, lfsr[7:0]}; // [R14] [R5]
		end else if (tick) begin
			ivl_cnt    <= ivl_cnt + 10'h001;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// packet out

	// one strobe per interval, every input slot with its code and level
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			tx_valid  <= 1'b0;
			tx_packet <= '0;
		end else begin
			tx_valid <= any_input && ivl_done;                       // [R5]
			if (any_input && ivl_done) begin
				for (int i = 0; i < wior_pkg::NPINS; i++) begin
					tx_packet.entry[i].valid            <= in_mask[i];               // [R6]
					tx_packet.entry[i].pin_pairing_code <= in_mask[i] ? link_code[i] : 8'h00;
					tx_packet.entry[i].level            <= in_mask[i] & pin_in_q[i]; // [R6] [R1]
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// packet in

	logic [14:0] next_out;

	// match each local output against every reported input code
	always_comb begin
		next_out = pin_out;
		if (rx_valid) begin
			for (int o = 0; o < wior_pkg::NPINS; o++) begin
				for (int e = 0; e < wior_pkg::NPINS; e++) begin
					if (out_mask[o] && rx_packet.entry[e].valid
					    && is_input(rx_packet.entry[e].pin_pairing_code)
					    && (8'(-rx_packet.entry[e].pin_pairing_code) == link_code[o]))
						next_out[o] = rx_packet.entry[e].level;      // [R7] [R3]
				end
			end
		end
	end

	// outputs start low and change only on a peer packet, never on a timeout
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			pin_out <= 15'h0000;                                     // [R10]
		else
			pin_out <= next_out;                                     // [R4] [R17]
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// register read

	// register map, one 32-bit word each, data in the low bits:
	//   0x00  channel, read and write, eight bits, reset 128
	//   0x04  status, bit 0 set while any pin is an input
	//   0x08  output levels, one bit per pin slot
	//   0x0C  sampled input levels, one cycle behind the pins
	//   0x10  random seed; a read returns the running generator
	//   0x40  pairing codes, word 8*port+pin from this base
	//
	// pairing code words by port:
	//   port 0 pins 0-5  at 0x40 to 0x54, slots 0 to 5
	//   port 1 pins 0-7  at 0x60 to 0x7C, slots 6 to 13
	//   port 2 pin 1     at 0x84, slot 14, the red indicator
	// holes in the code window read zero and ignore writes,
	// so software walking the whole window does no harm.
	//
	// limitation: the seed word only loads a nonzero value; zero
	// would lock the generator and freeze the packet spacing.
	//
	// trade-off: reads are registered, so a read costs one cycle of
	// latency but the decode stays off the output timing path.
	//
	// the data word drops back to zero after its one cycle, which
	// lets a bus that ors several slaves together skip a mux.

	logic [3:0] rd_slot;
	assign rd_slot = addr_is_link ? link_slot(reg_addr) : 4'hF;

	// data one cycle after the strobe; unmapped words read zero
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= 32'h0000_0000;
			if (reg_addr == wior_pkg::REG_CHANNEL)
				reg_rdata <= {24'h000000, radio_channel};
			else if (reg_addr == wior_pkg::REG_STATUS)
				reg_rdata <= {31'h0, any_input};
			else if (reg_addr == wior_pkg::REG_OUT_LEVELS)
				reg_rdata <= {17'h0, pin_out};
			else if (reg_addr == wior_pkg::REG_IN_LEVELS)
				reg_rdata <= {17'h0, pin_in_q};
			else if (reg_addr == wior_pkg::REG_SEED)
				reg_rdata <= {16'h0000, lfsr};
			else if (rd_slot != 4'hF)
				reg_rdata <= {24'h000000, link_code[rd_slot]};
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule : wior_repeater

// ---- pkg/wior_pkg.sv ----
// package for the radio i/o repeater: register map, pin layout, timing, packet structs.
// assumes a single 100 MHz clock and a simple strobe register port.
package wior_pkg;
	// pin count: six on port 0, eight on port 1, one on port 2
	localparam int unsigned NPINS           = 15;
	localparam int unsigned PIN_IDX_W       = 4;
	localparam int unsigned P0_PINS         = 6;
	localparam int unsigned P1_PINS         = 8;
	localparam int unsigned P2_LED_INDEX    = 14;
	localparam int unsigned P1_FLOAT_A      = 6;
	localparam int unsigned P1_FLOAT_B      = 7;

	// register byte offsets
	localparam logic [7:0] REG_CHANNEL      = 8'h00;
	localparam logic [7:0] REG_STATUS       = 8'h04;
	localparam logic [7:0] REG_OUT_LEVELS   = 8'h08;
	localparam logic [7:0] REG_IN_LEVELS    = 8'h0C;
	localparam logic [7:0] REG_SEED         = 8'h10;
	localparam logic [7:0] REG_LINK_BASE    = 8'h40;
	localparam logic [7:0] REG_LINK_LAST    = 8'h84;

	// reset values
	localparam logic [7:0]  CHANNEL_RESET    = 8'h80;
	localparam logic [7:0]  LINK_DISABLED    = 8'h00;
	localparam logic [7:0]  LINK_P00_RESET   = 8'hFF;
	localparam logic [7:0]  LINK_LED_RESET   = 8'h01;
	localparam logic [7:0]  LINK_FORBIDDEN   = 8'h80;
	localparam logic [15:0] SEED_RESET       = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS        = 16'hB400;

	// timing
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned TX_MIN_MS       = 7;
	localparam int unsigned TX_MAX_MS       = 10;
	localparam int unsigned TICK_US         = 10;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned TX_MIN_TICKS    = (TX_MIN_MS * 1000 + TICK_US - 1) / TICK_US;
	localparam int unsigned TX_MAX_TICKS    = TX_MAX_MS * 1000 / TICK_US;
	localparam int unsigned TX_SPAN_TICKS   = TX_MAX_TICKS - TX_MIN_TICKS;
	localparam int unsigned TICK_CNT_W      = 10;
	localparam int unsigned IVL_CNT_W       = 10;

	// one entry of a packet: signed pairing code and sampled level
	typedef struct packed {
		logic       valid;
		logic [7:0] pin_pairing_code;
		logic       level;
	} wior_entry_s;

	// the whole packet, one entry per pin slot
	typedef struct packed {
		wior_entry_s [NPINS-1:0] entry;
	} wior_packet_s;

	// register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} wior_reg_req_s;
endpackage : wior_pkg

// ---- verif/wior_peer_model.sv ----
// partner model: one peer repeater on the shared channel, delivering packets it is handed.
// assumes the bench builds each packet and raises send for one cycle.
`timescale 1ns/1ps
module wior_peer_model (
	// from the bench
	input  wire logic                   send,
	input  wire logic [7:0]             chan,
	input  wire wior_pkg::wior_packet_s pkt,
	// towards the device
	input  wire logic [7:0]             radio_channel,
	output wior_pkg::wior_packet_s      rx_packet,
	output logic                        rx_valid
);
	// only a peer on the same channel is heard
	// bench puts a single entry in each packet, so no two inputs collide
	assign rx_valid  = send && (chan == radio_channel);
	// between packets the lines show the inverse, so stale data cannot pass
	assign rx_packet = send ? pkt : wior_pkg::wior_packet_s'(~pkt);
endmodule : wior_peer_model

// ---- verif/wior_repeater_chk.sv ----
// checker for the repeater core: bus answer timing, reset levels, pin and packet relations.
// assumes it is bound to wior_repeater and sees only its ports.
`timescale 1ns/1ps
module wior_repeater_chk (
	// clock and reset
	input wire logic                   sys_clk,
	input wire logic                   rst_b,
	// register port
	input wire logic [7:0]             reg_addr,
	input wire logic [31:0]            reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [31:0]            reg_rdata,
	// pins and radio
	input wire logic [14:0]            pin_out,
	input wire logic [14:0]            pin_oe,
	input wire logic [14:0]            pin_pullup,
	input wire logic [7:0]             radio_channel,
	input wire wior_pkg::wior_packet_s tx_packet,
	input wire logic                   tx_valid,
	input wire logic                   rx_valid
);
	// one tick of slack below 7 ms, since tick phase is free
	localparam int GAP_MIN = 699000;
	logic [19:0] gap;
	logic        bad_entry;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////
	// cycles since reset or last packet, saturating
	always_ff @(posedge sys_clk) begin
		if (!rst_b || tx_valid) gap <= 20'h00000;
		else if (gap != 20'hFFFFF) gap <= gap + 20'h00001;
	end
	// packet entries must be inputs, never disabled or -128
	always_comb begin
		bad_entry = 1'b0;
		for (int i = 0; i < 15; i++) begin
			if (tx_packet.entry[i].valid && (!tx_packet.entry[i].pin_pairing_code[7] ||
				tx_packet.entry[i].pin_pairing_code == 8'h80)) bad_entry = 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
		else $error("read data outside its cycle");
	a_chan_reset: assert property (disable iff (1'b0) !rst_b |=> radio_channel == 8'h80)
		else $error("channel not at default after reset");
	a_out_reset: assert property (disable iff (1'b0) !rst_b |=> pin_out == 15'h0000)
		else $error("outputs not low in reset");
	a_chan_write: assert property (reg_wr && reg_addr == 8'h00 |=>
		radio_channel == $past(reg_wdata[7:0])) else $error("channel write lost");
	a_out_hold: assert property (!rx_valid && !reg_wr |=> $stable(pin_out))
		else $error("outputs moved without a packet");
	a_tx_pulse: assert property (tx_valid |=> !tx_valid)
		else $error("packet strobe longer than one cycle");
	a_tx_gap: assert property (tx_valid |-> gap >= GAP_MIN)
		else $error("packets closer than the interval");
	a_tx_entries: assert property (tx_valid |-> !bad_entry)
		else $error("packet carries a non-input entry");
	a_float_pins: assert property (pin_pullup[7:6] == 2'b00)
		else $error("floating pins got a pull-up");
	a_out_nopull: assert property ((pin_oe & pin_pullup) == 15'h0000)
		else $error("driven pin has a pull-up");
endmodule : wior_repeater_chk

// ---- verif/wior_repeater_tb_top.sv ----
// bench for the repeater core: reset state, codes, received levels, channel filter.
// assumes the peer model and checker are compiled before it.
`timescale 1ns/1ps
module wior_repeater_tb_top;
	logic                   sys_clk = 1'b0;
	logic                   rst_b = 1'b0;
	logic [7:0]             reg_addr = 8'h00;
	logic [31:0]            reg_wdata = 32'h00000000;
	logic                   reg_wr = 1'b0;
	logic                   reg_rd = 1'b0;
	logic [31:0]            reg_rdata;
	logic [14:0]            pin_in = 15'h7FFF;
	logic [14:0]            pin_out, pin_oe, pin_pullup, exp_out;
	logic [7:0]             radio_channel, chan;
	logic [7:0]             peer_chan = 8'h80;
	wior_pkg::wior_packet_s tx_packet, rx_packet;
	wior_pkg::wior_packet_s peer_pkt = '0;
	logic                   tx_valid, rx_valid, lvl;
	logic                   peer_send = 1'b0;
	logic                   rd_pend = 1'b0;
	logic [31:0]            exp_q[$];
	int                     fail_count = 0;
	int                     samples_checked = 0;
	int                     cycles = 0;
	always #5 sys_clk = ~sys_clk;
	wior_repeater uut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.radio_channel(radio_channel), .tx_packet(tx_packet), .tx_valid(tx_valid),
		.rx_packet(rx_packet), .rx_valid(rx_valid));
	wior_peer_model peer (.send(peer_send), .chan(peer_chan), .pkt(peer_pkt),
		.radio_channel(radio_channel), .rx_packet(rx_packet), .rx_valid(rx_valid));
	////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic summarize();
		if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	// strobes stay up so accesses can run back to back
	task automatic wr(logic [7:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
	endtask : rd
	task automatic idle(int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : idle
	// one peer packet with a single entry
	task automatic rx1(int slot, logic [7:0] code, logic l);
		wior_pkg::wior_packet_s p;
		p = '0;
		p.entry[slot] = {1'b1, code, l};
		peer_pkt <= p;
		peer_send <= 1'b1;
		@(posedge sys_clk);
		peer_send <= 1'b0;
		@(posedge sys_clk);
	endtask : rx1
	task automatic pins(logic [14:0] oe, logic [14:0] pu);
		@(negedge sys_clk);
		check("pin_oe", {17'h0, oe}, {17'h0, pin_oe});
		check("pin_pullup", {17'h0, pu}, {17'h0, pin_pullup});
		check("pin_out", {17'h0, exp_out}, {17'h0, pin_out});
		@(posedge sys_clk);
	endtask : pins
	////////////////////////////////////////////////////////////////
	// read data meet the oldest note one cycle after the strobe
	always @(negedge sys_clk) begin
		if (rd_pend) check("reg_rdata", exp_q.pop_front(), reg_rdata);
		rd_pend = reg_rd;
	end
	// hang guard, far above the few hundred cycles needed
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		void'($urandom(35));
		exp_out = 15'h0000;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		idle(2);
		pins(15'h4000, 15'h0001);
		rd(8'h00, 32'h80);
		rd(8'h40, 32'hFF);
		rd(8'h44, 32'h00);
		rd(8'h04, 32'h01);
		rd(8'h20, 32'h00);
		rd(8'h7C, 32'h00);
		rd(8'h84, 32'h01);
		chan = 8'($urandom);
		wr(8'h00, {24'h0, chan});
		rd(8'h00, {24'h0, chan});
		peer_chan <= chan;
		// slot1 in -5, slot6 floating in, slots 2 and 3 out 5, slot4 -128
		wr(8'h44, 32'hFB);
		wr(8'h60, 32'hFE);
		wr(8'h48, 32'h05);
		wr(8'h4C, 32'h05);
		wr(8'h50, 32'h80);
		idle(2);
		pins(15'h400C, 15'h0003);
		repeat (4) begin
			pin_in <= 15'($urandom);
			@(posedge sys_clk);
		end
		pins(15'h400C, 15'h0003);
		repeat (4) begin
			lvl = 1'($urandom);
			rx1(int'($urandom_range(14)), 8'hFB, lvl);
			exp_out[3:2] = {2{lvl}};
			pins(15'h400C, 15'h0003);
		end
		rx1(0, 8'hFF, 1'b1);
		exp_out[14] = 1'b1;
		rx1(5, 8'h01, 1'b0);
		pins(15'h400C, 15'h0003);
		rd(8'h08, {17'h0, exp_out});
		idle(1);
		// a peer on another channel is never heard; levels then hold
		peer_chan <= chan ^ 8'h01;
		rx1(0, 8'hFF, 1'b0);
		idle(300);
		pins(15'h400C, 15'h0003);
		rst_b <= 1'b0;
		idle(2);
		rst_b <= 1'b1;
		exp_out = 15'h0000;
		idle(2);
		pins(15'h4000, 15'h0001);
		summarize();
	end
endmodule : wior_repeater_tb_top
bind wior_repeater wior_repeater_chk chk (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .radio_channel(radio_channel),
	.tx_packet(tx_packet), .tx_valid(tx_valid), .rx_valid(rx_valid));
